// ### pkg/mct_pkg.sv
// constants for the match/capture counter-timer
package mct_pkg;
    localparam int CNT_W_DEFAULT = 32;  // counter width; 16 for the narrow instances
    localparam int NUM_CAP       = 4;   // capture channels per timer
    localparam int NUM_MATCH     = 4;   // match registers per timer
    localparam int PIN_CAPS      = 3;   // capture channels fed from pins
    localparam int CMP_CAP_IDX   = 3;   // capture channel fed by comparator_result
    // external match output actions
    localparam logic [1:0] EMA_NONE   = 2'h0;
    localparam logic [1:0] EMA_LOW    = 2'h1;
    localparam logic [1:0] EMA_HIGH   = 2'h2;
    localparam logic [1:0] EMA_TOGGLE = 2'h3;
    // capture edge select bits
    localparam int CAPSEL_RISE = 0;
    localparam int CAPSEL_FALL = 1;
    // counter mode edge select
    localparam logic [1:0] CM_TIMER = 2'h0;
    localparam logic [1:0] CM_RISE  = 2'h1;
    localparam logic [1:0] CM_FALL  = 2'h2;
    localparam logic [1:0] CM_BOTH  = 2'h3;
endpackage : mct_pkg

// ### rtl/mct_timer.sv
// match/capture counter-timer core with prescaler, captures and match outputs
`timescale 1ns/1ns
// Contract
// - counter and prescaler come in 32-bit or 16-bit width per instance
// - timer mode counts system clock cycles divided by the prescaler
// - software programmable prescaler as wide as the counter
// - selectable timer mode or counter mode counting external input events
// - four capture channels copy the counter on a selected input transition
// - each capture event may raise an interrupt under a per-channel enable
// - three captures come from pins, one from the comparator result
// - four match registers; continuous match keeps counting, optional interrupt
// - stop match halts the counter, optional interrupt
// - reset match returns the counter to zero, optional interrupt
// - four match outputs go low, high, toggle or stay on match
module mct_timer import mct_pkg::*; #(
    parameter int CNT_W = CNT_W_DEFAULT                  // counter and prescaler width
) (
    input  wire logic                    MCLK,           // system clock
    input  wire logic                    NRST,           // async reset, active low
    input  wire logic                    COUNT_ENABLE,   // counting allowed
    input  wire logic                    COUNT_RESET,    // hold counters at zero
    input  wire logic [1:0]              COUNT_MODE,     // timer or counter edge select
    input  wire logic [1:0]              COUNT_SRC_SEL,  // capture channel used as count input
    input  wire logic [CNT_W-1:0]        PRESCALE_MAX,   // prescaler terminal value
    input  wire logic [PIN_CAPS-1:0]     CAP_PIN,        // capture pins, asynchronous
    input  wire logic                    COMPARATOR_RESULT, // comparator output, async
    input  wire logic [2*NUM_CAP-1:0]    CAP_EDGE_SEL,   // per channel rise/fall enable
    input  wire logic [NUM_CAP-1:0]      CAP_IRQ_EN,     // per channel interrupt enable
    input  wire logic [NUM_MATCH*CNT_W-1:0] MATCH_VAL,   // match values, packed
    input  wire logic [NUM_MATCH-1:0]    MATCH_IRQ_EN,   // interrupt on match
    input  wire logic [NUM_MATCH-1:0]    MATCH_RESET_EN, // reset counter on match
    input  wire logic [NUM_MATCH-1:0]    MATCH_STOP_EN,  // stop counter on match
    input  wire logic [2*NUM_MATCH-1:0]  MATCH_ACTION,   // output action per match
    input  wire logic [NUM_MATCH-1:0]    EXT_MATCH_CLR,  // clear pulse per match output
    output logic      [CNT_W-1:0]        COUNT,          // main counter
    output logic      [CNT_W-1:0]        PRESCALE_COUNT, // prescaler counter
    output logic                         RUNNING,        // counter enabled, not stopped
    output logic      [NUM_CAP*CNT_W-1:0] CAP_VAL,       // capture registers, packed
    output logic      [NUM_MATCH-1:0]    EXT_MATCH,      // external match outputs
    output logic      [NUM_CAP-1:0]      CAP_IRQ,        // capture event pulses
    output logic      [NUM_MATCH-1:0]    MATCH_IRQ       // match event pulses
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [NUM_CAP-1:0] sync1_r;
    logic [NUM_CAP-1:0] sync2_r;
    logic [NUM_CAP-1:0] prev_r;
    wire  [NUM_CAP-1:0] raw_in = {COMPARATOR_RESULT, CAP_PIN};

    // two flops per asynchronous input, a third to find edges
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r  <= '0;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    wire [NUM_CAP-1:0] rise_w = sync2_r & ~prev_r;
    wire [NUM_CAP-1:0] fall_w = ~sync2_r & prev_r;

    // ------------------------------------------------------------
    // count source selection
    // ------------------------------------------------------------
    logic                 stopped_r;
    wire                  ev_rise  = rise_w[COUNT_SRC_SEL];
    wire                  ev_fall  = fall_w[COUNT_SRC_SEL];
    wire                  timer_md = (COUNT_MODE == CM_TIMER);
    // counter mode advances the prescaler on the chosen external edges
    wire                  ext_tick = (COUNT_MODE == CM_RISE && ev_rise) ||
                                     (COUNT_MODE == CM_FALL && ev_fall) ||
                                     (COUNT_MODE == CM_BOTH && (ev_rise || ev_fall));
    wire                  run_w    = COUNT_ENABLE && !stopped_r && !COUNT_RESET;
    wire                  pre_tick = run_w && (timer_md || ext_tick);
    wire                  pre_term = (PRESCALE_COUNT == PRESCALE_MAX);
    wire                  cnt_tick = pre_tick && pre_term;

    // ------------------------------------------------------------
    // match decode
    // ------------------------------------------------------------
    logic [NUM_MATCH-1:0] hit_w;
    genvar gm;
    generate
        for (gm = 0; gm < NUM_MATCH; gm++) begin : g_match
            // a match fires when the counter is about to leave the matched value
            assign hit_w[gm] = cnt_tick && (COUNT == MATCH_VAL[gm*CNT_W +: CNT_W]);
        end
    endgenerate
    wire any_reset = |(hit_w & MATCH_RESET_EN);
    wire any_stop  = |(hit_w & MATCH_STOP_EN);

    // ------------------------------------------------------------
    // prescaler and main counter
    // ------------------------------------------------------------
    wire [CNT_W-1:0] pre_nxt = pre_term ? '0 : PRESCALE_COUNT + 1'b1;
    wire [CNT_W-1:0] cnt_nxt = any_reset ? '0 : COUNT + 1'b1;

    // reset match takes priority over plain increment; stop freezes value
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            PRESCALE_COUNT <= '0;
            COUNT          <= '0;
        end else if (COUNT_RESET) begin
            PRESCALE_COUNT <= '0;
            COUNT          <= '0;
        end else if (pre_tick) begin
            PRESCALE_COUNT <= pre_nxt;
            if (cnt_tick)
                COUNT <= cnt_nxt;
        end
    end

    // stop latch; cleared when software drops the enable
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST)
            stopped_r <= 1'b0;
        else if (any_stop)
            stopped_r <= 1'b1;
        else if (!COUNT_ENABLE)
            stopped_r <= 1'b0;
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST)
            RUNNING <= 1'b0;
        else
            RUNNING <= COUNT_ENABLE && !any_stop && !stopped_r && !COUNT_RESET;
    end

    // ------------------------------------------------------------
    // captures and match outputs, one slice per channel
    // ------------------------------------------------------------
    logic [NUM_CAP-1:0] cap_ev_w;
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CAP; gc++) begin : g_cap
            assign cap_ev_w[gc] = (CAP_EDGE_SEL[2*gc+CAPSEL_RISE] && rise_w[gc]) ||
                                  (CAP_EDGE_SEL[2*gc+CAPSEL_FALL] && fall_w[gc]);
            always_ff @(posedge MCLK or negedge NRST) begin
                if (!NRST) begin
                    CAP_VAL[gc*CNT_W +: CNT_W] <= '0;
                    CAP_IRQ[gc]                <= 1'b0;
                end else begin
                    if (cap_ev_w[gc])
                        CAP_VAL[gc*CNT_W +: CNT_W] <= COUNT;
                    CAP_IRQ[gc] <= cap_ev_w[gc] && CAP_IRQ_EN[gc];
                end
            end
        end
        for (gm = 0; gm < NUM_MATCH; gm++) begin : g_emo
            wire [1:0] act = MATCH_ACTION[2*gm +: 2];
            // a match action wins over a simultaneous software clear
            always_ff @(posedge MCLK or negedge NRST) begin
                if (!NRST) begin
                    EXT_MATCH[gm] <= 1'b0;
                    MATCH_IRQ[gm] <= 1'b0;
                end else begin
                    MATCH_IRQ[gm] <= hit_w[gm] && MATCH_IRQ_EN[gm];
                    if (hit_w[gm] && act != EMA_NONE) begin
                        unique case (act)
                            EMA_LOW:    EXT_MATCH[gm] <= 1'b0;
                            EMA_HIGH:   EXT_MATCH[gm] <= 1'b1;
                            EMA_TOGGLE: EXT_MATCH[gm] <= ~EXT_MATCH[gm];
                            default:    EXT_MATCH[gm] <= EXT_MATCH[gm];
                        endcase
                    end else if (EXT_MATCH_CLR[gm]) begin
                        EXT_MATCH[gm] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_stop_hit;
        any_stop && !COUNT_RESET;
    endsequence

    // counter mode: a selected rising edge arrives while the prescaler sits at its end
    sequence s_src_rise_wrap;
        COUNT_MODE == CM_RISE && rise_w[COUNT_SRC_SEL] && run_w && pre_term && !any_reset;
    endsequence

    // comparator edge: the first flop rises, one edge later the edge flag fires
    // with rise capture enabled on that channel
    sequence s_cmp_edge;
        $rose(sync1_r[CMP_CAP_IDX]) ##1
            (rise_w[CMP_CAP_IDX] && CAP_EDGE_SEL[2*CMP_CAP_IDX+CAPSEL_RISE]);
    endsequence

    prescale_wrap_a: assert property (@(posedge MCLK) disable iff (!NRST)
        (pre_tick && pre_term && !COUNT_RESET) |=> (PRESCALE_COUNT == '0))
        else $error("prescaler did not restart at terminal value");
    count_step_a: assert property (@(posedge MCLK) disable iff (!NRST)
        (cnt_tick && !any_reset && !COUNT_RESET) |=> (COUNT == $past(COUNT) + 1'b1))
        else $error("counter did not advance on prescaler wrap");
    count_hold_a: assert property (@(posedge MCLK) disable iff (!NRST)
        (!cnt_tick && !COUNT_RESET) |=> $stable(COUNT))
        else $error("counter moved without a prescaler wrap");
    match_reset_a: assert property (@(posedge MCLK) disable iff (!NRST)
        (any_reset && !COUNT_RESET) |=> (COUNT == '0))
        else $error("reset match did not clear the counter");
    match_stop_a: assert property (@(posedge MCLK) disable iff (!NRST)
        s_stop_hit |=> (!RUNNING && stopped_r) ##1 (stopped_r || !COUNT_ENABLE))
        else $error("stop match did not halt the counter");
    capture_copy_a: assert property (@(posedge MCLK) disable iff (!NRST)
        cap_ev_w[0] |=> (CAP_VAL[CNT_W-1:0] == $past(COUNT)))
        else $error("capture 0 did not take the counter value");
    capture_irq_a: assert property (@(posedge MCLK) disable iff (!NRST)
        CAP_IRQ[CMP_CAP_IDX] |-> $past(cap_ev_w[CMP_CAP_IDX] && CAP_IRQ_EN[CMP_CAP_IDX]))
        else $error("comparator capture interrupt without cause");
    match_toggle_a: assert property (@(posedge MCLK) disable iff (!NRST)
        (hit_w[0] && MATCH_ACTION[1:0] == EMA_TOGGLE) |=> (EXT_MATCH[0] != $past(EXT_MATCH[0])))
        else $error("toggle action did not invert match output 0");

    // ------------------------------------------------------------
    // assertions: counting, refusal, the stop latch and the comparator capture
    // ------------------------------------------------------------
    // below its terminal value the prescaler steps by one per accepted tick
    prescale_step_a: assert property (@(posedge MCLK) disable iff (!NRST)
        (pre_tick && !pre_term) |=> (PRESCALE_COUNT == $past(PRESCALE_COUNT) + 1'b1))
        else $error("prescaler did not step by one");
    // while disabled or stopped neither counter may move; a leak here would let
    // a stopped timer creep past its stop value
    count_refused_a: assert property (@(posedge MCLK) disable iff (!NRST)
        (!run_w && !COUNT_RESET) |=> ($stable(PRESCALE_COUNT) && $stable(COUNT)))
        else $error("counter moved while not running");
    // counter mode ignores plain clock cycles between selected edges
    event_only_a: assert property (@(posedge MCLK) disable iff (!NRST)
        (!timer_md && !ext_tick && !COUNT_RESET) |=> $stable(PRESCALE_COUNT))
        else $error("prescaler moved without an input event");
    event_step_a: assert property (@(posedge MCLK) disable iff (!NRST)
        s_src_rise_wrap |=> (COUNT == $past(COUNT) + 1'b1))
        else $error("counter missed a selected input edge");
    // the stop latch survives until software drops the enable
    stop_latch_a: assert property (@(posedge MCLK) disable iff (!NRST)
        (stopped_r && COUNT_ENABLE) |=> stopped_r)
        else $error("stop latch released while enabled");
    stop_flag_a: assert property (@(posedge MCLK) disable iff (!NRST)
        stopped_r |-> !RUNNING)
        else $error("running flag high while stopped");
    // the comparator channel copies the count one edge after its edge flag
    cmp_capture_a: assert property (@(posedge MCLK) disable iff (!NRST)
        s_cmp_edge |=> (CAP_VAL[CMP_CAP_IDX*CNT_W +: CNT_W] == $past(COUNT)))
        else $error("comparator edge did not capture the counter");

    // ------------------------------------------------------------
    // assertions: per channel captures and match outputs
    // ------------------------------------------------------------
    // every channel gets the same checks, so a fault confined to one slice of
    // the packed vectors is still caught, except in capture copy (checked on
    // slices 0 and 3 only) and the toggle action (checked on slice 0 only)
    genvar gq;
    genvar gk;
    generate
        for (gq = 0; gq < NUM_CAP; gq++) begin : g_cap_chk
            // a rise on the first flop reaches the edge flag one edge later
            edge_detect_a: assert property (@(posedge MCLK) disable iff (!NRST)
                $rose(sync1_r[gq]) |=> rise_w[gq])
                else $error("input edge lost in the synchroniser");
            // a capture register only changes on its own event
            capture_hold_a: assert property (@(posedge MCLK) disable iff (!NRST)
                !cap_ev_w[gq] |=> $stable(CAP_VAL[gq*CNT_W +: CNT_W]))
                else $error("capture register changed without an event");
            // an enabled capture event always gives an interrupt pulse
            capture_irq_set_a: assert property (@(posedge MCLK) disable iff (!NRST)
                (cap_ev_w[gq] && CAP_IRQ_EN[gq]) |=> CAP_IRQ[gq])
                else $error("enabled capture event gave no interrupt pulse");
            // the pulse lasts one cycle unless another event follows at once
            capture_irq_clear_a: assert property (@(posedge MCLK) disable iff (!NRST)
                !cap_ev_w[gq] |=> !CAP_IRQ[gq])
                else $error("capture interrupt without an event");
        end
        for (gk = 0; gk < NUM_MATCH; gk++) begin : g_match_chk
            wire [1:0] act_k = MATCH_ACTION[2*gk +: 2];
            // set actions force the level whatever it was before
            match_high_a: assert property (@(posedge MCLK) disable iff (!NRST)
                (hit_w[gk] && act_k == EMA_HIGH) |=> EXT_MATCH[gk])
                else $error("set-high action failed on a match output");
            match_low_a: assert property (@(posedge MCLK) disable iff (!NRST)
                (hit_w[gk] && act_k == EMA_LOW) |=> !EXT_MATCH[gk])
                else $error("set-low action failed on a match output");
            // do-nothing leaves the pin alone unless software clears it
            match_keep_a: assert property (@(posedge MCLK) disable iff (!NRST)
                (hit_w[gk] && act_k == EMA_NONE && !EXT_MATCH_CLR[gk]) |=> $stable(EXT_MATCH[gk]))
                else $error("do-nothing action moved a match output");
            // a software clear lands only in cycles without a match action
            match_clear_a: assert property (@(posedge MCLK) disable iff (!NRST)
                (EXT_MATCH_CLR[gk] && !(hit_w[gk] && act_k != EMA_NONE)) |=> !EXT_MATCH[gk])
                else $error("software clear did not lower a match output");
            // one pulse per match; a second pulse needs a second match
            match_irq_a: assert property (@(posedge MCLK) disable iff (!NRST)
                (hit_w[gk] && MATCH_IRQ_EN[gk]) |=>
                    MATCH_IRQ[gk] ##1 (!MATCH_IRQ[gk] || $past(hit_w[gk])))
                else $error("match interrupt pulse missing or too long");
            match_irq_cause_a: assert property (@(posedge MCLK) disable iff (!NRST)
                MATCH_IRQ[gk] |-> $past(hit_w[gk] && MATCH_IRQ_EN[gk]))
                else $error("match interrupt without an enabled match");
        end
    endgenerate
endmodule : mct_timer

// ### tb/pin_model.sv
// far-side model: capture pins and comparator output
`timescale 1ns/1ns
module pin_model (
    input  wire logic       MCLK,              // system clock
    input  wire logic [3:0] level,             // wanted levels, bit 3 is the comparator
    output logic      [2:0] cap_pin,           // capture pins
    output logic            comparator_result  // comparator output
);
    // pins follow the wanted levels one edge later, like a registered far side
    always_ff @(posedge MCLK) begin
        {comparator_result, cap_pin} <= level;
    end
endmodule : pin_model

// ### tb/mct_timer_test.sv
// self-checking bench for the counter-timer, narrow instance
`timescale 1ns/1ns
module mct_timer_test import mct_pkg::*; ;
    localparam int W = 16;
    logic MCLK = 0, NRST = 0, en = 0, rst = 0;
    logic [1:0] mode = CM_TIMER, src = 2'h0;
    logic [W-1:0] pmax = '0;
    logic [3:0] lvl = '0, cie = '0, mie = '0, mrs = '0, mst = '0, clr = '0;
    logic [7:0] esel = '0, act = '0;
    logic [4*W-1:0] mval = '0;
    wire [W-1:0] cnt, pcnt;
    wire [4*W-1:0] cap;
    wire [3:0] em, cirq, mirq;
    wire [2:0] cpin;
    wire run, cmp;
    int n_errors = 0, tests_run = 0, cyc = 0, n;
    logic [1:0] acts [6] = '{EMA_HIGH, EMA_NONE, EMA_LOW, EMA_TOGGLE, EMA_TOGGLE, EMA_TOGGLE};
    logic [5:0] ex = 6'b101011; // match output after each action, bit i for step i
    // -----------------------------
    // clock, parts, timeout
    // -----------------------------
    always #4 MCLK = ~MCLK;
    mct_timer #(.CNT_W(W)) dut (.MCLK(MCLK), .NRST(NRST), .COUNT_ENABLE(en),
        .COUNT_RESET(rst), .COUNT_MODE(mode), .COUNT_SRC_SEL(src), .PRESCALE_MAX(pmax),
        .CAP_PIN(cpin), .COMPARATOR_RESULT(cmp), .CAP_EDGE_SEL(esel), .CAP_IRQ_EN(cie),
        .MATCH_VAL(mval), .MATCH_IRQ_EN(mie), .MATCH_RESET_EN(mrs), .MATCH_STOP_EN(mst),
        .MATCH_ACTION(act), .EXT_MATCH_CLR(clr), .COUNT(cnt), .PRESCALE_COUNT(pcnt),
        .RUNNING(run), .CAP_VAL(cap), .EXT_MATCH(em), .CAP_IRQ(cirq), .MATCH_IRQ(mirq));
    pin_model far (.MCLK(MCLK), .level(lvl), .cap_pin(cpin), .comparator_result(cmp));
    // a hang costs one mismatch rather than a silent stall
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // -----------------------------
    // tasks
    // -----------------------------
    task automatic check(input string nm, input logic [W-1:0] exp, input logic [W-1:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // counts edges up to and including the one that shows the event pulse
    // the pulse vectors are read live; a copied argument would never change
    task automatic wait_evt(input bit cap_side, input int ch, output int k);
        k = 0;
        do begin
            @(posedge MCLK);
            k++;
        end while ((cap_side ? cirq[ch] : mirq[ch]) !== 1'b1 && k < 300);
    endtask : wait_evt
    task automatic pulse(input int ch, input int times);
        repeat (times) begin
            lvl[ch] <= 1'b1;
            repeat (4) @(posedge MCLK);
            lvl[ch] <= 1'b0;
            repeat (4) @(posedge MCLK);
        end
    endtask : pulse
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    // -----------------------------
    // tests
    // -----------------------------
    initial begin
        repeat (8) @(posedge MCLK);
        NRST <= 1'b1;
        @(posedge MCLK);
        // timer mode, wrap every 2 ticks, reset on match at 2: period (2+1)*(1+1)
        en <= 1'b1; pmax <= 16'h0001; mval[W-1:0] <= 16'h0002; mrs <= 4'h1; mie <= 4'h1;
        for (int i = 0; i < 6; i++) begin
            act[1:0] <= acts[i];
            wait_evt(1'b0, 0, n);
            if (i > 0) check("match period", 16'h0006, 16'(n));
            check("count after reset match", 16'h0000, cnt);
            check("prescaler after wrap", 16'h0000, pcnt);
            check("match output", {15'h0000, ex[i]}, {15'h0000, em[0]});
        end
        $display("test match actions done");
        // counter mode on rising edges of capture pin 0, no prescale; the held
        // counter gives the software clear a quiet window on match output 0
        en <= 1'b0; rst <= 1'b1; mrs <= '0; mie <= '0; act <= '0; mode <= CM_RISE;
        pmax <= '0; mval <= {16'hffff, 16'hffff, 16'h0007, 16'hffff}; mst <= 4'h2;
        clr <= 4'h1;
        repeat (4) @(posedge MCLK);
        rst <= 1'b0; en <= 1'b1;
        clr <= '0;
        check("cleared match output", 16'h0000, {15'h0000, em[0]});
        pulse(0, 5);
        check("events counted", 16'h0005, cnt);
        check("running", 16'h0001, {15'h0000, run});
        // comparator rise captures the frozen count on channel 3; pin 0 captures too
        esel <= 8'h41; cie <= 4'h8; lvl[3] <= 1'b1;
        wait_evt(1'b1, 3, n);
        check("capture latency", 16'h0005, 16'(n));
        check("comparator capture", 16'h0005, cap[3*W +: W]);
        check("capture irq seen", 16'h0001, {15'h0000, cirq[3]});
        @(posedge MCLK);
        check("capture irq cleared", 16'h0000, {15'h0000, cirq[3]});
        $display("test capture done");
        // match 1 at 7 stops: the edge leaving 7 gives 8, later edges are refused
        pulse(0, 5);
        check("stopped count", 16'h0008, cnt);
        check("stopped flag", 16'h0000, {15'h0000, run});
        check("pin capture", 16'h0008, cap[W-1:0]);
        $display("test stop match done");
        report_and_stop();
    end
endmodule : mct_timer_test
